// ---- bench/fcs_flash_model.sv ----
/*
 Program flash model: a word read answers one cycle later.
 Assumes the scanner pulses its read strobe with a word address.
*/
`timescale 1ns/1ps
module fcs_flash_model
(
	input  wire logic        clk_i,
	input  wire logic        rd_i,
	input  wire logic [14:0] addr_i,
	output logic      [15:0] data_o
);
	logic [15:0] mem [0:32767];
	// Data is valid only the cycle after a read; else it churns
	always_ff @(posedge clk_i)
		data_o <= rd_i ? mem[addr_i] : data_o ^ 16'hA5C3;
endmodule // fcs_flash_model

// ---- bench/fcs_scanner_assertions.sv ----
/*
 Port-level checker of the flash checksum scanner.
 Assumes binding onto fcs_scanner with ports hooked up by name.
*/
`timescale 1ns/1ps
module fcs_scanner_assertions
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [3:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        sleep_i,
	input wire logic        flash_rd_o,
	input wire logic        cpu_stall_o,
	input wire logic        hold_reset_o,
	input wire logic        nmi_o,
	input wire logic [7:0]  nmi_vector_o
);
	// ****************
	// Request decode
	// ****************
	logic req;
	logic go;
	logic rd_st;
	// Taken requests; go is an enable write that must launch a scan
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign go = req && wb_we_i && wb_adr_i[3:2] == 2'h0 && wb_sel_i[0]
		&& wb_dat_i[0] && !wb_dat_i[7] && !cpu_stall_o && !nmi_o && !sleep_i;
	assign rd_st = req && !wb_we_i && wb_adr_i[3:2] == 2'h2;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// ****************
	// Properties
	// ****************
	AST_ACK: assert property (req |=> wb_ack_o)
		else $error("ack missing after request");
	AST_NO_EARLY: assert property (go |=> (!flash_rd_o) [*4])
		else $error("fetch inside start delay");
	AST_ON_TIME: assert property (go ##1 !sleep_i [*5] |-> flash_rd_o)
		else $error("scan did not start on time");
	AST_GAP: assert property (flash_rd_o |=> (!flash_rd_o) [*2])
		else $error("fetches closer than three cycles");
	AST_STALL: assert property (flash_rd_o |-> cpu_stall_o)
		else $error("fetch without cpu stall");
	AST_SLEEP: assert property (sleep_i && $past(sleep_i)
		|-> !flash_rd_o)
		else $error("fetch while asleep");
	AST_BUSY_RD: assert property (rd_st && cpu_stall_o
		|=> wb_dat_o[1:0] == 2'h1)
		else $error("status wrong while busy");
	AST_VEC: assert property (nmi_vector_o == 8'h00)
		else $error("wrong failure vector");
	AST_NMI_KEEP: assert property (nmi_o |=> nmi_o)
		else $error("nmi dropped");
	AST_HOLD_KEEP: assert property (hold_reset_o |=> hold_reset_o)
		else $error("reset hold dropped");
	// Main scenarios reached
	cover property (flash_rd_o);
	cover property ($rose(nmi_o));
	cover property ($rose(hold_reset_o));
endmodule // fcs_scanner_assertions

bind fcs_scanner fcs_scanner_assertions u_chk (.clk_i, .rst_i, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
	.wb_ack_o, .sleep_i, .flash_rd_o, .cpu_stall_o, .hold_reset_o, .nmi_o,
	.nmi_vector_o);

// ---- bench/tb_flash_crc_memory_scanner.sv ----
/*
 Self-checking bench of the flash checksum scanner.
 Assumes the scanner, its checker and the flash model are compiled.
*/
`timescale 1ns/1ps
module tb_flash_crc_memory_scanner;
	logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic sleep_i = 0, reset_init_i = 0, reset_scan_source_fuse_i = 0;
	logic [3:0]  wb_adr_i = 0, wb_sel_i = 4'h1;
	logic [31:0] wb_dat_i = 0, wb_dat_o;
	logic [1:0]  reset_section_i = 0;
	logic [7:0]  boot_end_fuse_i = 8'h01, app_end_fuse_i = 8'h02;
	logic [14:0] flash_addr_o;
	logic [15:0] flash_data_i;
	logic wb_ack_o, flash_rd_o, cpu_stall_o, hold_reset_o, nmi_o;
	logic [7:0]  nmi_vector_o;
	int n_errors = 0, checks = 0, cycles = 0, seed = 32'h0767;
	int n_rd = 0, rd_base = 0, t_first = 0, t_last = 0;
	// Small flash keeps full scans short
	fcs_scanner #(.ADDR_W(16), .FLASH_END(16'h05FF)) dut (.clk_i, .rst_i,
		.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .sleep_i, .reset_init_i,
		.reset_scan_source_fuse_i, .reset_section_i, .boot_end_fuse_i,
		.app_end_fuse_i, .flash_addr_o, .flash_rd_o, .flash_data_i,
		.cpu_stall_o, .hold_reset_o, .nmi_o, .nmi_vector_o);
	fcs_flash_model u_flash (.clk_i(clk_i), .rd_i(flash_rd_o),
		.addr_i(flash_addr_o), .data_o(flash_data_i));
	// ****************
	// Clock and watchdog
	// ****************
	always #50 clk_i = ~clk_i;
	// A hung handshake ends the run as a failure
	// Fetch count and span of the current scan, stamped in one process
	always @(posedge clk_i)
	begin
		cycles++;
		if (flash_rd_o === 1'b1)
		begin
			if (n_rd == rd_base)
				t_first = cycles;
			t_last = cycles;
			n_rd++;
		end
		if (cycles > 40000)
		begin
			n_errors++;
			test_done();
		end
	end
	// ****************
	// Reference model
	// ****************
	function automatic int sec_end(input int s);
		return s == 2 ? 256 : s == 1 ? 512 : 16'h0600;
	endfunction
	function automatic logic [15:0] crc_of(input int n);
		logic [15:0] c;
		logic [7:0]  b;
		c = 16'hFFFF;
		for (int i = 0; i < n - 2; i++)
		begin
			b = (i % 2) ? u_flash.mem[i/2][15:8] : u_flash.mem[i/2][7:0];
			for (int k = 7; k >= 0; k--)
				c = {c[14:0], 1'b0} ^ ((c[15] ^ b[k]) ? 16'h1021 : 16'h0);
		end
		return c;
	endfunction
	// Store the reference sum, high byte at the lower address
	task automatic place(input int n);
		logic [15:0] c;
		c = crc_of(n);
		u_flash.mem[n/2-1] = {c[7:0], c[15:8]};
	endtask
	// ****************
	// Bus and compare tasks
	// ****************
	task automatic wb(input logic [3:0] a, input logic w, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, d};
		// Only the watchdog ends a wait for the answer
		do
		begin
			@(posedge clk_i);
		end
		while (wb_ack_o !== 1'b1);
		q = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask
	task automatic chk(input string s, input logic [15:0] e,
		input logic [15:0] g);
		checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic rdc(input string s, input logic [3:0] a, input logic [7:0] e);
		logic [7:0] q;
		wb(a, 1'b0, 8'h00, q);
		chk(s, e, q);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [7:0] q;
		wb(a, 1'b1, d, q);
	endtask
	// Let the three-cycle start delay pass, then poll busy
	task automatic wait_idle();
		logic [7:0] q;
		repeat (5) @(posedge clk_i);
		do
		begin
			wb(4'h8, 1'b0, 8'h00, q);
		end
		while (q[0] !== 1'b0);
	endtask
	task automatic arm();
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		reset_section_i <= 2'h2;
		reset_scan_source_fuse_i <= 1'b1;
		reset_init_i <= 1'b1;
		wait_idle();
		reset_init_i <= 1'b0;
	endtask
	task automatic test_done();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ****************
	// Main sequence
	// ****************
	initial
	begin
		for (int i = 0; i < 768; i++)
			u_flash.mem[i] = $random(seed);
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		rdc("ctrl_first", 4'h0, 8'h00);
		rdc("ctrl_second", 4'h4, 8'h00);
		rdc("status", 4'h8, 8'h02);
		rdc("unmapped", 4'hC, 8'h00);
		for (int s = 0; s < 3; s++)
		begin
			place(sec_end(s));
			rd_base = n_rd;
			wr(4'h4, s[7:0]);
			wr(4'h0, 8'h01);
			wait_idle();
			rdc("status", 4'h8, 8'h02);
			rdc("ctrl_first", 4'h0, 8'h01);
			rdc("ctrl_second", 4'h4, s[7:0]);
			chk("fetches", 16'(sec_end(s) / 2), 16'(n_rd - rd_base));
			chk("span", 16'(3 * sec_end(s) / 2 - 3), 16'(t_last - t_first));
		end
		// Sleep in the start delay, then again in mid-scan
		rd_base = n_rd;
		wr(4'h0, 8'h01);
		sleep_i <= 1'b1;
		repeat (40) @(posedge clk_i);
		rdc("status", 4'h8, 8'h00);
		sleep_i <= 1'b0;
		repeat (40) @(posedge clk_i);
		sleep_i <= 1'b1;
		repeat (20) @(posedge clk_i);
		rdc("status", 4'h8, 8'h01);
		sleep_i <= 1'b0;
		wait_idle();
		rdc("status", 4'h8, 8'h02);
		chk("fetches", 16'(sec_end(2) / 2), 16'(n_rd - rd_base));
		// Writes while busy: enable off taken, interrupt enable and section refused
		wr(4'h0, 8'h01);
		repeat (6) @(posedge clk_i);
		wr(4'h0, 8'h02);
		wr(4'h4, 8'h01);
		wait_idle();
		rdc("status", 4'h8, 8'h02);
		rdc("ctrl_first", 4'h0, 8'h00);
		rdc("ctrl_second", 4'h4, 8'h02);
		wr(4'h0, 8'h01);
		repeat (8) @(posedge clk_i);
		wr(4'h0, 8'h80);
		rdc("ctrl_first", 4'h0, 8'h00);
		rdc("ctrl_second", 4'h4, 8'h00);
		rdc("status", 4'h8, 8'h00);
		chk("stall", 8'h00, {7'h0, cpu_stall_o});
		// The strobe must leave the interrupt enable standing
		wr(4'h0, 8'h02);
		wr(4'h0, 8'h80);
		rdc("ctrl_first", 4'h0, 8'h02);
		u_flash.mem[3] = ~u_flash.mem[3];
		wr(4'h4, 8'h02);
		wr(4'h0, 8'h03);
		// A strobe while busy with the interrupt enable set must not cut the scan
		repeat (6) @(posedge clk_i);
		wr(4'h0, 8'h81);
		wait_idle();
		rdc("status", 4'h8, 8'h00);
		chk("nmi", 8'h01, {7'h0, nmi_o});
		chk("vector", 8'h00, nmi_vector_o);
		wr(4'h0, 8'h80);
		rdc("ctrl_first", 4'h0, 8'h03);
		wr(4'h4, 8'h01);
		rdc("ctrl_second", 4'h4, 8'h02);
		place(256);
		arm();
		chk("nmi", 8'h00, {7'h0, nmi_o});
		rdc("ctrl_first", 4'h0, 8'h01);
		rdc("ctrl_second", 4'h4, 8'h12);
		chk("hold", 8'h00, {7'h0, hold_reset_o});
		u_flash.mem[3] = ~u_flash.mem[3];
		arm();
		chk("hold", 8'h01, {7'h0, hold_reset_o});
		test_done();
	end
endmodule // tb_flash_crc_memory_scanner

// ---- core/fcs_crc16.sv ----
/*
 Bytewise CRC-16 generator, MSB first.
 Assumes the caller presets it before each scan.
*/
`timescale 1ns/1ps
`include "fcs_params.svh"
module fcs_crc16
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        init_i,
	input  wire logic        byte_valid_i,
	input  wire logic [7:0]  byte_i,
	output logic      [15:0] crc_o
);
	// ****************************************************************
	// Byte step
	// ****************************************************************
	// Eight serial steps folded into one cycle
	function automatic logic [15:0] fcs_step(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		logic        fb;
		r = c;
		for (int i = 7; i >= 0; i--)
		begin
			fb = r[15] ^ d[i];
			r = {r[14:0], 1'b0} ^ (fb ? `FCS_CRC_POLY : 16'h0000);
		end
		return r;
	endfunction

	// Preset wins over a byte in the same cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i || init_i)
			crc_o <= `FCS_CRC_INIT;
		else if (byte_valid_i)
			crc_o <= fcs_step(crc_o, byte_i);
	end
endmodule // fcs_crc16

// ---- core/fcs_scanner.sv ----
/*
 Flash checksum scanner with a classic Wishbone register slave.
 Assumes a flash read port that answers a word address with data one
 cycle later, byte-addressed little-endian words, and fuse ends given
 in 256-byte units by the surrounding system.
*/
`timescale 1ns/1ps
`include "fcs_params.svh"
module fcs_scanner #(
	parameter int ADDR_W  = 16,
	parameter int FLASH_END = 16'hFFFF
)
(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [3:0]        wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	input  wire logic              sleep_i,
	input  wire logic              reset_init_i,
	input  wire logic              reset_scan_source_fuse_i,
	input  wire logic [1:0]        reset_section_i,
	input  wire logic [7:0]        boot_end_fuse_i,
	input  wire logic [7:0]        app_end_fuse_i,
	output logic [ADDR_W-2:0]      flash_addr_o,
	output logic                   flash_rd_o,
	input  wire logic [15:0]       flash_data_i,
	output logic                   cpu_stall_o,
	output logic                   hold_reset_o,
	output logic                   nmi_o,
	output logic [7:0]             nmi_vector_o
);
	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	// The last flash byte must be odd and fit the byte address space
	if (ADDR_W < 9 || ADDR_W > 24 || FLASH_END >= (1 << ADDR_W)
		|| FLASH_END % 2 != 1)
	begin : g_bad_params
		$error("fcs_scanner: ADDR_W or FLASH_END out of range");
	end

	// ****************************************************************
	// State
	// ****************************************************************
	fcs_pkg::fcs_state_t state;
	logic               enable;
	logic               fail_ie;
	logic [1:0]         mode;
	logic [1:0]         section;
	logic               ok;
	logic               busy;
	logic               nmi_fired;
	logic               reset_scan;
	logic               strobe_pend;
	logic               restart;
	logic [1:0]         delay_cnt;
	logic [1:0]         fetch_cnt;
	logic [ADDR_W-2:0]  word_addr;
	logic [ADDR_W-2:0]  last_word;
	logic               data_valid;
	logic               hi_pend;
	logic [7:0]         hi_byte;
	logic               byte_valid;
	logic [7:0]         byte_val;
	logic [15:0]        crc;
	logic               crc_init;
	logic               init_q;

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	logic       bus_req;
	logic       wr_lane0;
	logic       wr_first;
	logic       wr_second;
	logic [1:0] reg_idx;
	assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign reg_idx   = wb_adr_i[3:2];
	assign wr_lane0  = bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i[1:0] == 2'h0;
	assign wr_first  = wr_lane0 && reg_idx == `FCS_IDX_CTRL_FIRST
		&& !nmi_fired;
	assign wr_second = wr_lane0 && reg_idx == `FCS_IDX_CTRL_SECOND
		&& !busy && !nmi_fired;

	// Strobe acceptance depends on the interrupt enable
	logic strobe_ok;
	assign strobe_ok = wr_first && wb_dat_i[`FCS_BIT_RESET]
		&& (!fail_ie || !busy);

	// Last word index of the chosen section, byte end is fuse*256, or FLASH_END+1 for full flash
	function automatic logic [ADDR_W-2:0] fcs_last(input logic [1:0] s,
		input logic [7:0] be, input logic [7:0] ae);
		logic [ADDR_W:0] e;
		e = '0;
		case (s)
			2'h1:    e = (ADDR_W+1)'(ae) * (ADDR_W+1)'(`FCS_SECTION_UNIT);
			2'h2:    e = (ADDR_W+1)'(be) * (ADDR_W+1)'(`FCS_SECTION_UNIT);
			default: e = (ADDR_W+1)'(FLASH_END) + (ADDR_W+1)'(1);
		endcase
		return (ADDR_W-1)'((e - (ADDR_W+1)'(1)) >> 1);
	endfunction

	// Bus ack one cycle, read data registered
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= bus_req;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_dat_o <= 32'h0000_0000;
		else if (bus_req && !wb_we_i)
		begin
			case (reg_idx)
				`FCS_IDX_CTRL_FIRST:  wb_dat_o <= {30'h0, fail_ie, enable};
				`FCS_IDX_CTRL_SECOND: wb_dat_o <= {26'h0, mode, 2'h0, section};
				`FCS_IDX_RESULT:      wb_dat_o <= {30'h0, ok && !busy, busy};
				default:              wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// ****************************************************************
	// Control registers
	// ****************************************************************
	// Strobe clears registers one cycle after it was written
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			strobe_pend <= 1'b0;
		else
			strobe_pend <= strobe_ok;
	end

	// Catch the reset-time arming at release
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			init_q <= 1'b0;
		else
			init_q <= reset_init_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			enable  <= 1'b0;
			mode    <= 2'h0;
			section <= 2'h0;
			restart <= 1'b0;
		end
		else if (strobe_pend)
		begin
			enable  <= 1'b0;
			mode    <= 2'h0;
			section <= 2'h0;
			restart <= 1'b0;
		end
		else if (reset_init_i && !init_q && reset_scan_source_fuse_i)
		begin
			enable  <= 1'b1;
			mode    <= 2'h1;
			section <= reset_section_i;
			restart <= 1'b1;
		end
		else
		begin
			restart <= 1'b0;
			if (wr_first)
			begin
				enable  <= wb_dat_i[`FCS_BIT_ENABLE];
				restart <= wb_dat_i[`FCS_BIT_ENABLE];
			end
			if (wr_second)
			begin
				mode    <= wb_dat_i[`FCS_MODE_MSB:`FCS_MODE_LSB];
				section <= wb_dat_i[`FCS_SEL_MSB:`FCS_SEL_LSB];
			end
		end
	end

	// Only system reset clears the interrupt enable
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			fail_ie <= 1'b0;
		else if (wr_first && wb_dat_i[`FCS_BIT_FAIL_IE] && !busy)
			fail_ie <= 1'b1;
	end

	// ****************************************************************
	// Scan sequencer
	// ****************************************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i || strobe_pend)
		begin
			state      <= fcs_pkg::FCS_IDLE;
			delay_cnt  <= 2'h0;
			fetch_cnt  <= 2'h0;
			word_addr  <= '0;
			last_word  <= '0;
			busy       <= 1'b0;
			reset_scan <= 1'b0;
		end
		else
		begin
			case (state)
				fcs_pkg::FCS_IDLE:
				begin
					if (restart && !busy)
					begin
						state      <= fcs_pkg::FCS_DELAY;
						delay_cnt  <= 2'h0;
						reset_scan <= reset_init_i;
					end
				end
				fcs_pkg::FCS_DELAY:
				begin
					// Sleep inside the delay holds the start
					if (!sleep_i)
					begin
						delay_cnt <= delay_cnt + 2'h1;
						if (delay_cnt == 2'(`FCS_START_DELAY - 1))
						begin
							state     <= fcs_pkg::FCS_SCAN;
							busy      <= 1'b1;
							word_addr <= '0;
							fetch_cnt <= 2'h0;
							last_word <= fcs_last(section, boot_end_fuse_i,
								app_end_fuse_i);
						end
					end
				end
				fcs_pkg::FCS_SCAN:
				begin
					if (!sleep_i)
					begin
						if (fetch_cnt == 2'(`FCS_FETCH_PERIOD - 1))
						begin
							fetch_cnt <= 2'h0;
							if (word_addr == last_word)
								state <= fcs_pkg::FCS_CHECK;
							else
								word_addr <= word_addr + 1'b1;
						end
						else
							fetch_cnt <= fetch_cnt + 2'h1;
					end
				end
				fcs_pkg::FCS_CHECK:
				begin
					// Wait for the last byte to enter the generator
					if (!byte_valid && !hi_pend && !data_valid)
					begin
						state <= fcs_pkg::FCS_IDLE;
						busy  <= 1'b0;
					end
				end
				default: state <= fcs_pkg::FCS_IDLE;
			endcase
		end
	end

	// One fetch per three cycles while scanning
	assign flash_rd_o   = state == fcs_pkg::FCS_SCAN && !sleep_i
		&& fetch_cnt == 2'h0;
	assign flash_addr_o = word_addr;
	assign cpu_stall_o  = busy && mode == `FCS_MODE_PRIORITY
		|| busy && reset_scan;

	// ****************************************************************
	// Byte stream
	// ****************************************************************
	// Low byte first so bytes ascend; the word's high byte follows
	always_ff @(posedge clk_i)
	begin
		if (rst_i || strobe_pend)
		begin
			data_valid <= 1'b0;
			hi_pend    <= 1'b0;
			hi_byte    <= 8'h00;
			byte_valid <= 1'b0;
			byte_val   <= 8'h00;
		end
		else
		begin
			data_valid <= flash_rd_o;
			byte_valid <= 1'b0;
			if (data_valid)
			begin
				byte_valid <= 1'b1;
				byte_val   <= flash_data_i[7:0];
				hi_byte    <= flash_data_i[15:8];
				hi_pend    <= 1'b1;
			end
			else if (hi_pend)
			begin
				byte_valid <= 1'b1;
				byte_val   <= hi_byte;
				hi_pend    <= 1'b0;
			end
		end
	end

	assign crc_init = state == fcs_pkg::FCS_DELAY;

	fcs_crc16 u_crc
	(
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.init_i       (crc_init),
		.byte_valid_i (byte_valid),
		.byte_i       (byte_val),
		.crc_o        (crc)
	);

	// ****************************************************************
	// Result and failure
	// ****************************************************************
	// Running over the stored checksum (high byte first) leaves zero
	logic scan_done;
	assign scan_done = state == fcs_pkg::FCS_CHECK && !byte_valid
		&& !hi_pend && !data_valid;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ok <= 1'b1;
		else if (scan_done)
			ok <= crc == 16'h0000;
		else if (strobe_pend || restart)
			ok <= 1'b0;
	end

	// Sticky until system reset, no mask exists
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			nmi_fired <= 1'b0;
		else if (scan_done && crc != 16'h0000 && fail_ie)
			nmi_fired <= 1'b1;
	end

	// Failed reset-time scan keeps the core in reset
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			hold_reset_o <= 1'b0;
		else if (scan_done && crc != 16'h0000 && reset_scan)
			hold_reset_o <= 1'b1;
	end

	assign nmi_o        = nmi_fired;
	assign nmi_vector_o = `FCS_FAIL_VECTOR;
endmodule // fcs_scanner

// ---- pkg/fcs_params.svh ----
/*
 Constants of the flash checksum scanner: register offsets, field
 positions, reset values and timing counts.
 Assumes inclusion by bare name from the design files.
*/
//
// Operation
// - A scan begins three cycles after the enable bit is written.
// - A failed scan armed at reset keeps the device held in reset.
// - Scan armed at reset shows enable one, mode nonzero, section chosen.
// - Priority mode gives the scanner the flash and stalls the CPU.
// - One 16-bit flash word is fetched every third clock cycle.
// - Checksum fills last two section bytes, high first; end is fuse*256.
// - A checksum mismatch clears the pass flag.
// - Pass flag cleared with interrupt enable set raises a sticky NMI.
// - Interrupt enable clears only on system reset.
// - Setting the interrupt enable works only while not busy.
// - Failure interrupt uses vector 0x00 and ignores global masking.
// - Scanner pauses during CPU sleep and resumes where it stopped.
// - Sleep in the start delay holds the start until wake-up.
// - Reset strobe bit 7 clears control and status one cycle later.
// - Strobe acts anytime if interrupt enable is zero, else when idle.
// - After a failure interrupt, writes to the first control are ignored.
// - Second control ignores writes while busy or after an interrupt.
// - Enable stays one after a check; writing one again restarts.
// - Writing enable zero stops only after the ongoing check ends.
// - Mode field bits 5:4, code 0x0 is priority; others reserved.
// - Section field bits 1:0: full, boot plus application, boot only.
// - Generator uses polynomial x^16 + x^12 + x^5 + 1.
// - Checksum register presets to all ones before a scan.
// - Bytes go in ascending order from zero, MSB first.
// - Pass flag is one after reset, cleared on enable, zero while busy.
`ifndef FCS_PARAMS_SVH
`define FCS_PARAMS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define FCS_IDX_CTRL_FIRST   2'h0
`define FCS_IDX_CTRL_SECOND  2'h1
`define FCS_IDX_RESULT       2'h2
`define FCS_CTRL_FIRST_RST   8'h00
`define FCS_CTRL_SECOND_RST  8'h00
`define FCS_BIT_ENABLE       0
`define FCS_BIT_FAIL_IE      1
`define FCS_BIT_RESET        7
`define FCS_BIT_BUSY         0
`define FCS_BIT_OK           1
`define FCS_MODE_MSB         5
`define FCS_MODE_LSB         4
`define FCS_SEL_MSB          1
`define FCS_SEL_LSB          0
`define FCS_MODE_PRIORITY    2'h0
`define FCS_FAIL_VECTOR      8'h00

// ****************************************************************
// Timing, checksum and section size
// ****************************************************************
`define FCS_START_DELAY      3
`define FCS_FETCH_PERIOD     3
`define FCS_CRC_INIT         16'hFFFF
`define FCS_CRC_POLY         16'h1021
`define FCS_SECTION_UNIT     256

`endif

// ---- pkg/fcs_pkg.sv ----
/*
 Types of the flash checksum scanner.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package fcs_pkg;
	typedef enum logic [1:0] {
		FCS_SEL_FULL,
		FCS_SEL_BOOT_APP,
		FCS_SEL_BOOT,
		FCS_SEL_RESERVED
	} fcs_section_t;

	typedef enum {
		FCS_IDLE,
		FCS_DELAY,
		FCS_SCAN,
		FCS_CHECK
	} fcs_state_t;
endpackage
